// >>> inc/cos_blk_if.sv
// Block timing and sync signals shared inside the scheduler
`timescale 1ns/1ps
`default_nettype none
interface cos_blk_if;
	import cos_pkg::*;
	logic                 blk_stb;
	logic                 bic_ok;
	logic                 frame_head;
	logic                 sync_rst;
	logic                 blk_sync;
	logic                 frame_sync;
	logic [CNT_W-1:0]     blk_cnt;
	logic                 vslot_stb;
	logic [7:0]           vslot_idx;
	modport sync_mp (input blk_stb, bic_ok, frame_head, sync_rst, output blk_sync, frame_sync);
	modport slot_mp (input blk_stb, frame_head, output blk_cnt, vslot_stb, vslot_idx);
	modport top_mp (output blk_stb, bic_ok, frame_head, sync_rst,
		input blk_sync, frame_sync, blk_cnt, vslot_stb, vslot_idx);
endinterface
`default_nettype wire

// >>> inc/cos_pkg.sv
// Constants and types of the correction output scheduler
package cos_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_OUT  = 8'h08;
	// Control register fields
	localparam int CB_FRAME   = 0;
	localparam int CB_RTB     = 1;
	localparam int CB_VHALT   = 2;
	localparam int CB_SYNCRST = 4;
	localparam int CB_ALL     = 5;
	localparam logic [5:0] CTRL_RST = 6'h00;
	// Status register fields
	localparam int ST_CNT   = 0;
	localparam int ST_BSYNC = 9;
	localparam int ST_FSYNC = 10;
	localparam int ST_VRUN  = 11;
	localparam int ST_VPEND = 12;
	// Output register fields (status_byte_one in the low byte)
	localparam int SB_FSYNC = 5;
	localparam int SB_VERT  = 7;
	localparam int OF_BLK   = 8;
	localparam int OF_REQ   = 16;
	// Frame layout
	localparam int N_DATA        = 190;
	localparam int VSLOT_FIRST   = 29;
	localparam int VSLOT_LAST    = 218;
	localparam int HPHASE_LAST   = 28;
	localparam int FRAME_BLKS    = 272;
	localparam int FRAME_BLKS_RT = 284;
	localparam int CNT_W         = 9;
	// Timing
	localparam int CLK_HZ     = 10_000_000;
	localparam int BLK_MS     = 18;
	localparam int HOLD_V_MS  = 9;
	localparam int BLK_CYC    = BLK_MS * (CLK_HZ / 1000);
	localparam int HOLD_V_CYC = HOLD_V_MS * (CLK_HZ / 1000);
	localparam int SYNC_MISS  = 3;
	typedef enum logic [1:0] {
		SY_HUNT = 2'b00,
		SY_BLK  = 2'b01,
		SY_FRM  = 2'b11
	} cos_sync_e;
endpackage

// >>> rtl/cos_slot.sv
// Received-block counter and post-vertical slot generator
`timescale 1ns/1ps
`default_nettype none
module cos_slot (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Block timing
	cos_blk_if.slot_mp bus
);
	import cos_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             stb;
		logic [7:0]       idx;
	} cos_slot_s;

	cos_slot_s        state_ff;
	cos_slot_s        nxt_state;
	logic [CNT_W-1:0] cnt_new;

	always_comb begin
		nxt_state     = state_ff;
		nxt_state.stb = 1'b0;
		cnt_new       = bus.frame_head ? CNT_W'(1) : state_ff.cnt + CNT_W'(1);
		if (bus.blk_stb) begin
			nxt_state.cnt = cnt_new;
			// Fixed slot per data block, whether or not it will be offered
			if (cnt_new >= CNT_W'(VSLOT_FIRST) && cnt_new <= CNT_W'(VSLOT_LAST)) begin
				nxt_state.stb = 1'b1;
				nxt_state.idx = 8'(cnt_new - CNT_W'(VSLOT_FIRST));
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign bus.blk_cnt   = state_ff.cnt;
	assign bus.vslot_stb = state_ff.stb;
	assign bus.vslot_idx = state_ff.idx;
endmodule
`default_nettype wire

// >>> rtl/cos_sync.sv
// Block and frame synchronization tracker
`timescale 1ns/1ps
`default_nettype none
module cos_sync #(
	parameter int MISS = cos_pkg::SYNC_MISS
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Block timing
	cos_blk_if.sync_mp bus
);
	import cos_pkg::*;

	typedef struct packed {
		cos_sync_e  st;
		logic [3:0] miss;
	} cos_sync_s;

	cos_sync_s state_ff;
	cos_sync_s nxt_state;

	always_comb begin
		nxt_state = state_ff;
		if (bus.sync_rst) begin
			nxt_state.st   = SY_HUNT;
			nxt_state.miss = 4'h0;
		end else if (bus.blk_stb) begin
			if (bus.bic_ok) begin
				nxt_state.miss = 4'h0;
				case (state_ff.st)
					SY_HUNT: nxt_state.st = SY_BLK;
					SY_BLK: begin
						if (bus.frame_head) begin
							nxt_state.st = SY_FRM;
						end
					end
					SY_FRM: nxt_state.st = SY_FRM;
					default: nxt_state.st = SY_HUNT;
				endcase
			end else if (state_ff.st != SY_HUNT) begin
				// A few missed codes are tolerated before dropping sync
				if (state_ff.miss == 4'(MISS - 1)) begin
					nxt_state.st   = SY_HUNT;
					nxt_state.miss = 4'h0;
				end else begin
					nxt_state.miss = state_ff.miss + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= '{st: SY_HUNT, miss: 4'h0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign bus.blk_sync   = (state_ff.st != SY_HUNT);
	assign bus.frame_sync = (state_ff.st == SY_FRM);
endmodule
`default_nettype wire

// >>> rtl/cos_top.sv
// Output scheduler for corrected data blocks with APB control
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cos_top #(
	parameter int HOLD_H_CYC = cos_pkg::BLK_CYC,
	parameter int HOLD_V_CYC = cos_pkg::HOLD_V_CYC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Received block timing
	input  wire logic        blk_stb,
	input  wire logic        bic_ok,
	input  wire logic        frame_head,
	// Horizontal correction result of the previous packet
	input  wire logic        hdone,
	input  wire logic        h_ok,
	input  wire logic        h_crc_ok,
	input  wire logic        h_is_packet,
	input  wire logic        h_is_data,
	input  wire logic [7:0]  h_data_idx,
	input  wire logic [7:0]  h_blk_num,
	// Vertical correction result
	input  wire logic        vfix_stb,
	input  wire logic        vfix_ok,
	input  wire logic [7:0]  vfix_idx,
	// Outputs to host and correction engine
	output logic             xfer_req_n,
	output logic             out_vert,
	output logic [7:0]       out_blk,
	output logic             vert_go
);
	import cos_pkg::*;

	localparam int HW = $clog2(HOLD_H_CYC + HOLD_V_CYC + 1);

	typedef struct packed {
		logic [5:0]        ctrl;
		logic              srst;
		logic [31:0]       rdata;
		logic [N_DATA-1:0] hcur;
		logic [N_DATA-1:0] hprev;
		logic [N_DATA-1:0] vok;
		logic              vrun;
		logic              anyf;
		logic              all_sync;
		logic              pbs;
		logic              pfs;
		logic              req;
		logic              vert;
		logic              fs;
		logic [7:0]        blk;
		logic [HW-1:0]     hold;
		logic              vpend;
		logic [7:0]        vidx;
	} cos_top_s;

	cos_top_s state_ff;
	cos_top_s nxt_state;
	cos_blk_if bus ();

	logic wr;
	logic rd;
	logic setup;
	logic hit;
	logic good;
	logic hreq;
	logic complete;
	logic [CNT_W-1:0] flen;

	assign bus.blk_stb    = blk_stb;
	assign bus.bic_ok     = bic_ok;
	assign bus.frame_head = frame_head;
	assign bus.sync_rst   = state_ff.srst;

	cos_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.bus     (bus)
	);

	cos_slot u_slot (
		.pclk    (pclk),
		.presetn (presetn),
		.bus     (bus)
	);

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_OUT);
	endfunction

	always_comb begin
		wr    = psel && penable && pwrite;
		rd    = psel && penable && !pwrite;
		setup = psel && !penable;
		hit   = is_mapped(paddr);
		// Host picks the frame length; the device cannot detect it
		flen  = (state_ff.ctrl[CB_FRAME] && !state_ff.ctrl[CB_RTB]) ?
			CNT_W'(FRAME_BLKS_RT) : CNT_W'(FRAME_BLKS);
		complete = (bus.blk_cnt == flen) && state_ff.all_sync;
		good = h_ok && h_crc_ok && h_is_packet && state_ff.pbs && state_ff.pfs;
		// Non-packet stations never pass, so they raise nothing unless all-data mode (CB_ALL) is set
		hreq = hdone && (state_ff.ctrl[CB_ALL] || good);

		nxt_state      = state_ff;
		nxt_state.srst = 1'b0;

		// Register access
		if (wr && paddr == ADDR_CTRL) begin
			nxt_state.ctrl = pwdata[5:0] & 6'h27;
			nxt_state.srst = pwdata[CB_SYNCRST];
		end
		if (setup && !pwrite) begin
			nxt_state.rdata = 32'h0000_0000;
			case (paddr)
				ADDR_CTRL: nxt_state.rdata[5:0] = state_ff.ctrl;
				ADDR_STAT: begin
					nxt_state.rdata[ST_CNT +: CNT_W] = bus.blk_cnt;
					nxt_state.rdata[ST_BSYNC]        = bus.blk_sync;
					nxt_state.rdata[ST_FSYNC]        = bus.frame_sync;
					nxt_state.rdata[ST_VRUN]         = state_ff.vrun;
					nxt_state.rdata[ST_VPEND]        = state_ff.vpend;
				end
				ADDR_OUT: begin
					nxt_state.rdata[SB_VERT]      = state_ff.vert;
					nxt_state.rdata[SB_FSYNC]     = state_ff.fs;
					nxt_state.rdata[OF_BLK +: 8]  = state_ff.blk;
					nxt_state.rdata[OF_REQ]       = state_ff.req;
				end
				default: nxt_state.rdata = 32'h0000_0000;
			endcase
		end

		// Request lifetime: the buffer is overwritten once it runs out
		if (state_ff.req) begin
			nxt_state.hold = state_ff.hold - HW'(1);
			if (state_ff.hold == HW'(1)) begin
				nxt_state.req = 1'b0;
			end
		end
		// Reading the output word takes the one block of this request
		if (rd && paddr == ADDR_OUT) begin
			nxt_state.req = 1'b0;
		end

		// Sync seen by the block that has just ended
		if (blk_stb) begin
			nxt_state.pbs = bus.blk_sync;
			nxt_state.pfs = bus.frame_sync;
		end
		if (!bus.frame_sync) begin
			nxt_state.all_sync = 1'b0;
		end

		// Record horizontal failures of the frame being received
		if (hdone && !(h_ok && h_crc_ok) && state_ff.pfs) begin
			nxt_state.anyf = 1'b1;
			if (h_is_data && h_data_idx < 8'(N_DATA)) begin
				nxt_state.hcur[h_data_idx] = 1'b1;
			end
		end
		if (vfix_stb && state_ff.vrun && vfix_ok && vfix_idx < 8'(N_DATA)) begin
			nxt_state.vok[vfix_idx] = 1'b1;
		end

		// Frame head: decide on vertical correction of the frame just stored
		if (blk_stb && frame_head) begin
			// A failure reported on the head strobe still belongs to the stored frame
			nxt_state.vrun = complete && nxt_state.anyf && !state_ff.ctrl[CB_VHALT];
			nxt_state.hprev    = nxt_state.hcur;
			nxt_state.hcur     = '0;
			nxt_state.vok      = '0;
			nxt_state.anyf     = 1'b0;
			nxt_state.all_sync = bus.frame_sync;
		end

		// Horizontal request first, vertical waits for a free buffer
		if (hreq) begin
			nxt_state.req  = 1'b1;
			nxt_state.vert = 1'b0;
			nxt_state.fs   = state_ff.pfs;
			nxt_state.blk  = h_blk_num;
			nxt_state.hold = state_ff.vrun ? HW'(HOLD_V_CYC) : HW'(HOLD_H_CYC);
		end else if (state_ff.vpend && !state_ff.req) begin
			nxt_state.req   = 1'b1;
			nxt_state.vert  = 1'b1;
			nxt_state.fs    = bus.frame_sync;
			nxt_state.blk   = state_ff.vidx;
			nxt_state.hold  = HW'(HOLD_V_CYC);
			nxt_state.vpend = 1'b0;
		end

		// A new slot replaces an unserved one, so slots never drift
		if (bus.vslot_stb) begin
			// All-data mode still needs a frame that was corrected
			nxt_state.vpend = state_ff.vrun && (state_ff.ctrl[CB_ALL] ||
				(state_ff.hprev[bus.vslot_idx] && state_ff.vok[bus.vslot_idx]));
			nxt_state.vidx  = bus.vslot_idx;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff      <= '0;
			state_ff.ctrl <= CTRL_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign prdata     = state_ff.rdata;
	assign pready     = 1'b1;
	assign pslverr    = psel && penable && !hit;
	assign xfer_req_n = !state_ff.req;
	assign out_vert   = state_ff.vert;
	assign out_blk    = state_ff.blk;
	// Previous frame is corrected during the first received packets
	assign vert_go    = state_ff.vrun && (bus.blk_cnt <= CNT_W'(HPHASE_LAST));
endmodule
`default_nettype wire

// >>> sim/correction_output_scheduler_tb_top.sv
// Directed bench for the correction output scheduler
`timescale 1ns/1ps
`default_nettype none
module correction_output_scheduler_tb_top;
	import cos_pkg::*;
	localparam int HOLD_H = 40;
	localparam int HOLD_V = 20;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, e, quiet;
	logic [7:0]  paddr, h_data_idx, h_blk_num, vfix_idx, out_blk;
	logic [31:0] pwdata, prdata, d;
	logic        blk_stb, bic_ok, frame_head, hdone, h_ok, h_crc_ok, h_is_packet, h_is_data;
	logic        vfix_stb, vfix_ok, xfer_req_n, out_vert, vert_go;
	int          num_errors = 0;
	int          checks = 0;
	always #50 pclk = ~pclk;
	cos_top #(.HOLD_H_CYC(HOLD_H), .HOLD_V_CYC(HOLD_V)) dut_u (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .blk_stb, .bic_ok, .frame_head,
		.hdone, .h_ok, .h_crc_ok, .h_is_packet, .h_is_data, .h_data_idx, .h_blk_num, .vfix_stb,
		.vfix_ok, .vfix_idx, .xfer_req_n, .out_vert, .out_blk, .vert_go);
	cos_host host_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .xfer_req_n);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a);
		host_u.apb(1'b0, a, 32'h0, d, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		host_u.apb(1'b1, a, v, d, e);
	endtask
	// Strobe, then leave room for a slot offer to settle
	task automatic blk(input logic head);
		@(posedge pclk);
		blk_stb <= 1'b1;
		frame_head <= head;
		@(posedge pclk);
		blk_stb <= 1'b0;
		frame_head <= 1'b0;
		repeat (4) @(posedge pclk);
		#1;
	endtask
	task automatic hd(input logic ok, crc, pkt, input logic [7:0] idx);
		@(posedge pclk);
		hdone <= 1'b1;
		h_ok <= ok;
		h_crc_ok <= crc;
		h_is_packet <= pkt;
		h_data_idx <= idx;
		h_blk_num <= idx;
		@(posedge pclk);
		hdone <= 1'b0;
		@(posedge pclk);
		#1;
	endtask
	initial begin
		{blk_stb, frame_head, hdone, h_ok, h_crc_ok, h_is_packet, vfix_stb, vfix_ok} = '0;
		{bic_ok, h_is_data, quiet} = 3'h7;
		{h_data_idx, h_blk_num, vfix_idx} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_CTRL);
		chk(d, 32'h0);
		rd(ADDR_STAT);
		chk(d, 32'h0);
		rd(8'h0C);
		chk({d[30:0], e}, 32'h1);
		hd(1'b1, 1'b1, 1'b1, 8'h03);
		chk(32'(xfer_req_n), 32'h1);
		$display("reset and idle test done");
		for (int f = 0; f < 5; f++) begin
			if (f == 4) wr(ADDR_CTRL, 32'h20);
			for (int k = 1; k <= FRAME_BLKS; k++) begin
				blk(f > 0 && k == 1);
				if (f == 4) quiet &= xfer_req_n;
				if (f == 1 && k == 10) begin
					hd(1'b1, 1'b1, 1'b1, 8'h0A);
					chk(32'(xfer_req_n), 32'h0);
					host_u.take(d);
					chk(d & 32'h0001_FFA0, 32'h0001_0A20);
					@(posedge pclk);
					#1;
					chk(32'(xfer_req_n), 32'h1);
					rd(ADDR_STAT);
					chk(d & 32'h600, 32'h600);
				end
				if (f == 1 && k == 20) begin
					hd(1'b1, 1'b1, 1'b0, 8'h0B);
					chk(32'(xfer_req_n), 32'h1);
				end
				if (f == 1 && k == 30) begin
					// Left unread: the request must lapse when its hold runs out
					hd(1'b1, 1'b1, 1'b1, 8'h0C);
					repeat (HOLD_H - 3) @(posedge pclk);
					#1;
					chk(32'(xfer_req_n), 32'h0);
					repeat (3) @(posedge pclk);
					#1;
					chk(32'(xfer_req_n), 32'h1);
				end
				if (f == 2 && k == 20) begin
					hd(1'b0, 1'b1, 1'b1, 8'h05);
					chk(32'(xfer_req_n), 32'h1);
					hd(1'b1, 1'b0, 1'b1, 8'h06);
					chk(32'(xfer_req_n), 32'h1);
					hd(1'b0, 1'b1, 1'b1, 8'hBD);
					chk(32'(xfer_req_n), 32'h1);
				end
				if (f == 3 && k == 1) chk(32'(vert_go), 32'h1);
				if (f == 3 && k == 5) begin
					@(posedge pclk);
					vfix_stb <= 1'b1;
					vfix_ok <= 1'b1;
					vfix_idx <= 8'h05;
					@(posedge pclk);
					vfix_idx <= 8'hBD;
					@(posedge pclk);
					vfix_stb <= 1'b0;
				end
				if (f == 3 && k == 12) begin
					hd(1'b1, 1'b1, 1'b1, 8'h07);
					chk(32'({out_vert, xfer_req_n}), 32'h0);
					host_u.take(d);
				end
				if (f == 3 && k == VSLOT_FIRST) chk(32'({vert_go, xfer_req_n}), 32'h1);
				if (f == 3 && k == VSLOT_FIRST + 5) begin
					chk(32'({out_vert, xfer_req_n, out_blk}), 32'h205);
					host_u.take(d);
					chk(d & 32'h0001_FF80, 32'h0001_0580);
				end
				if (f == 3 && k == VSLOT_LAST) begin
					chk(32'({out_vert, xfer_req_n, out_blk}), 32'h2BD);
					host_u.take(d);
				end
				if (f == 3 && k == VSLOT_LAST + 1) chk(32'(xfer_req_n), 32'h1);
			end
			$display("frame %0d done", f);
		end
		chk(32'(quiet), 32'h1);
		hd(1'b0, 1'b0, 1'b0, 8'h09);
		chk(32'(xfer_req_n), 32'h0);
		host_u.take(d);
		wr(ADDR_CTRL, 32'h10);
		rd(ADDR_STAT);
		chk(d & 32'h600, 32'h0);
		rd(ADDR_CTRL);
		chk(d, 32'h0);
		blk(1'b0);
		rd(ADDR_STAT);
		chk(d & 32'h600, 32'h200);
		bic_ok <= 1'b0;
		repeat (SYNC_MISS - 1) blk(1'b0);
		rd(ADDR_STAT);
		chk(d & 32'h600, 32'h200);
		blk(1'b0);
		rd(ADDR_STAT);
		chk(d & 32'h600, 32'h0);
		$display("mode and sync reset test done");
		complete_run();
	end
	initial begin
		#4_000_000;
		num_errors++;
		complete_run();
	end
endmodule
bind cos_top cos_monitor #(.HOLD_H_CYC(HOLD_H_CYC)) mon_u (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pready, .pslverr, .hdone, .xfer_req_n, .out_vert, .out_blk, .vert_go);
`default_nettype wire

// >>> sim/cos_host.sv
// Host model: APB master that fetches offered blocks
`timescale 1ns/1ps
`default_nettype none
module cos_host (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB master
	output var logic         psel,
	output var logic         penable,
	output var logic         pwrite,
	output var logic [7:0]   paddr,
	output var logic [31:0]  pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// Transfer request
	input  wire logic        xfer_req_n
);
	import cos_pkg::*;
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
	end
	// Control writes carry frame kind and sync reset
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		wait (presetn === 1'b1);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait limit here; a stalled slave is left to the bench watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One read per request, well inside the hold time
	task automatic take(output logic [31:0] d);
		logic e;
		while (xfer_req_n !== 1'b0) begin
			@(posedge pclk);
		end
		apb(1'b0, ADDR_OUT, 32'h0, d, e);
	endtask
endmodule
`default_nettype wire

// >>> sim/cos_monitor.sv
// Port assertions for the correction output scheduler
`timescale 1ns/1ps
`default_nettype none
module cos_monitor #(
	parameter int HOLD_H_CYC = 40
) (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// APB
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	// Requests
	input wire logic       hdone,
	input wire logic       xfer_req_n,
	input wire logic       out_vert,
	input wire logic [7:0] out_blk,
	input wire logic       vert_go
);
	import cos_pkg::*;
	// Replacement by a newer request is not covered by this bound
	localparam int HOLD_MAX = HOLD_H_CYC + 2;
	logic acc;
	logic mapped;
	assign acc = psel && penable;
	assign mapped = paddr == ADDR_CTRL || paddr == ADDR_STAT || paddr == ADDR_OUT;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_NO_WAIT: assert property (acc |-> pready)
		else $error("access phase stalled");
	AST_ERR_UNMAPPED: assert property (acc && !mapped |-> pslverr)
		else $error("unmapped access not refused");
	AST_ERR_MAPPED: assert property (acc && mapped |-> !pslverr)
		else $error("mapped access refused");
	AST_REQ_CAUSE: assert property ($fell(xfer_req_n) |-> $past(hdone) || out_vert)
		else $error("request without a cause");
	AST_VERT_DATA_ONLY: assert property (!xfer_req_n && out_vert |-> out_blk < N_DATA)
		else $error("post-vertical offer beyond last data block");
	AST_VERT_NOT_EARLY: assert property (vert_go |-> !(out_vert && !xfer_req_n))
		else $error("post-vertical offer inside correction window");
	AST_READ_CLEARS: assert property (acc && !pwrite && paddr == ADDR_OUT
		&& !hdone && !xfer_req_n |=> xfer_req_n) else $error("request survived its read");
	AST_HOLD_LIMIT: assert property ($fell(xfer_req_n) |-> ##[1:HOLD_MAX] xfer_req_n)
		else $error("request held past its slot");
	AST_RESET_IDLE: assert property ($rose(presetn) |-> xfer_req_n && !out_vert && !vert_go)
		else $error("outputs not idle after reset");
endmodule
`default_nettype wire
